//--- src/fpes_regs.svh
// Register offsets, command codes and timing constants of the flash sequencer controller.
`ifndef FPES_REGS_SVH
`define FPES_REGS_SVH

`define FPES_OFS_CTRL 12'h000
`define FPES_OFS_ADDR 12'h004
`define FPES_OFS_DATA 12'h008
`define FPES_OFS_STAT 12'h00C
`define FPES_OFS_RDAT 12'h010

`define FPES_CTRL_GO_BIT 0
`define FPES_CTRL_OP_LSB 4
`define FPES_CTRL_OP_W 4
`define FPES_CTRL_ACC_BIT 8
`define FPES_CTRL_BYTE_BIT 9
`define FPES_CTRL_RST_BIT 10

`define FPES_STAT_BUSY_BIT 0
`define FPES_STAT_RB_BIT 1
`define FPES_STAT_SEC_BIT 2
`define FPES_STAT_BYP_BIT 3

`define FPES_UNLOCK1_ADDR 20'h00555
`define FPES_UNLOCK2_ADDR 20'h002AA
`define FPES_UNLOCK1_DATA 16'h00AA
`define FPES_UNLOCK2_DATA 16'h0055
`define FPES_CMD_SEC_ENTRY 16'h0088
`define FPES_CMD_EXIT 16'h0090
`define FPES_CMD_ZERO 16'h0000
`define FPES_CMD_PROG 16'h00A0
`define FPES_CMD_BYPASS 16'h0020
`define FPES_CMD_ERASE_SETUP 16'h0080
`define FPES_CMD_CHIP_ERASE 16'h0010
`define FPES_CMD_SECT_ERASE 16'h0030
`define FPES_CMD_SUSPEND 16'h00B0
`define FPES_CMD_RESET 16'h00F0

`define FPES_CLK_MHZ 25
`define FPES_TIMEOUT_NS 50000
`define FPES_TIMEOUT_CYC ((`FPES_TIMEOUT_NS * `FPES_CLK_MHZ) / 1000)
`define FPES_WE_LOW_CYC 3
`define FPES_WE_HIGH_CYC 2
`define FPES_RST_CYC 13

`endif

//--- src/fpes_pkg.sv
// Types shared by the flash sequencer controller.
package fpes_pkg;
   typedef enum logic [3:0] {
      FPES_OP_RESET, FPES_OP_SEC_ENTER, FPES_OP_SEC_EXIT, FPES_OP_PROG,
      FPES_OP_BYP_ENTER, FPES_OP_BYP_PROG, FPES_OP_BYP_EXIT, FPES_OP_CHIP_ERASE,
      FPES_OP_SECT_ERASE, FPES_OP_SECT_ADD, FPES_OP_SUSPEND, FPES_OP_READ
   } fpes_op_t;

   typedef struct packed {
      logic [19:0] addr;
      logic [15:0] data;
      logic last;
   } fpes_cyc_t;

   typedef struct packed {
      logic [19:0] addr;
      logic [15:0] dq_o;
      logic dq_oe;
      logic ce_n;
      logic we_n;
      logic oe_n;
      logic reset_n;
      logic byte_word_select;
      logic accel_high_voltage;
   } fpes_pins_t;
endpackage

//--- src/fpes_bus_cycle.sv
// One asynchronous flash write or read cycle, framed by write enable or output enable.
`timescale 1ns/1ps
module fpes_bus_cycle
   import fpes_pkg::*;
#(
   parameter int LOW_CYC = 3,
   parameter int HIGH_CYC = 2
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_start,
   input wire logic i_read,
   input wire fpes_cyc_t i_cyc,
   input wire logic [15:0] i_dq_sync,
   output logic o_done,
   output logic [15:0] o_rdata,
   output logic [19:0] o_addr,
   output logic [15:0] o_dq,
   output logic o_dq_oe,
   output logic o_we_n,
   output logic o_oe_n
);
   typedef enum logic [1:0] {FPES_BC_IDLE, FPES_BC_LOW, FPES_BC_HIGH} fpes_bc_st_t;
   typedef struct packed {
      fpes_bc_st_t st;
      logic [7:0] cnt;
      logic rd;
      logic done;
      logic [15:0] rdata;
      logic [19:0] addr;
      logic [15:0] dq;
      logic dq_oe;
      logic we_n;
      logic oe_n;
   } fpes_bc_t;
   fpes_bc_t s_q, s_d;

   always_comb begin
      s_d = s_q;
      s_d.done = 1'b0;
      case (s_q.st)
         FPES_BC_IDLE: begin
            if (i_start) begin
               s_d.st = FPES_BC_LOW;
               s_d.cnt = 8'h00;
               s_d.rd = i_read;
               s_d.addr = i_cyc.addr;
               s_d.dq = i_cyc.data;
               s_d.dq_oe = !i_read;
               s_d.we_n = i_read;
               s_d.oe_n = !i_read;
            end
         end
         FPES_BC_LOW: begin
            s_d.cnt = s_q.cnt + 8'h01;
            if (s_q.cnt == 8'(LOW_CYC - 1)) begin
               // Data is latched by the flash on this rising write enable edge.
               s_d.st = FPES_BC_HIGH;
               s_d.cnt = 8'h00;
               s_d.we_n = 1'b1;
               s_d.oe_n = 1'b1;
               if (s_q.rd) begin
                  s_d.rdata = i_dq_sync;
               end
            end
         end
         FPES_BC_HIGH: begin
            s_d.cnt = s_q.cnt + 8'h01;
            if (s_q.cnt == 8'(HIGH_CYC - 1)) begin
               s_d.st = FPES_BC_IDLE;
               s_d.dq_oe = 1'b0;
               s_d.done = 1'b1;
            end
         end
         default: s_d.st = FPES_BC_IDLE;
      endcase
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         s_q <= '{st: FPES_BC_IDLE, cnt: 8'h00, rd: 1'b0, done: 1'b0, rdata: 16'h0000,
                  addr: 20'h00000, dq: 16'h0000, dq_oe: 1'b0, we_n: 1'b1, oe_n: 1'b1};
      end else begin
         s_q <= s_d;
      end
   end

   assign o_done = s_q.done;
   assign o_rdata = s_q.rdata;
   assign o_addr = s_q.addr;
   assign o_dq = s_q.dq;
   assign o_dq_oe = s_q.dq_oe;
   assign o_we_n = s_q.we_n;
   assign o_oe_n = s_q.oe_n;

   chk_we_pulse_width: assert property (@(posedge i_clk) disable iff (i_rst)
      $fell(o_we_n) |-> !o_we_n [*3] ##1 o_we_n)
      else $error("write enable low time wrong");
   chk_data_stable: assert property (@(posedge i_clk) disable iff (i_rst)
      !o_we_n && !$fell(o_we_n) |-> $stable(o_dq) && $stable(o_addr) && o_dq_oe)
      else $error("bus changed during write pulse");
endmodule

//--- src/fpes_ctrl.sv
// Host-side controller that issues flash command sequences ordered over AXI4-Lite.
//
// Our own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`include "fpes_regs.svh"
module fpes_ctrl
   import fpes_pkg::*;
#(
   parameter int TIMEOUT_CYC = `FPES_TIMEOUT_CYC,
   parameter int RST_CYC = `FPES_RST_CYC
) (
   input wire logic I_CORE_CLK,
   input wire logic I_RST,
   input wire logic I_AWVALID,
   output logic O_AWREADY,
   input wire logic [11:0] I_AWADDR,
   input wire logic I_WVALID,
   output logic O_WREADY,
   input wire logic [31:0] I_WDATA,
   input wire logic [3:0] I_WSTRB,
   output logic O_BVALID,
   input wire logic I_BREADY,
   output logic [1:0] O_BRESP,
   input wire logic I_ARVALID,
   output logic O_ARREADY,
   input wire logic [11:0] I_ARADDR,
   output logic O_RVALID,
   input wire logic I_RREADY,
   output logic [31:0] O_RDATA,
   output logic [1:0] O_RRESP,
   output logic [19:0] O_FL_ADDR,
   output logic [15:0] O_FL_DQ,
   output logic O_FL_DQ_OE,
   input wire logic [15:0] I_FL_DQ,
   output logic O_FL_CE_N,
   output logic O_FL_WE_N,
   output logic O_FL_OE_N,
   output logic O_FL_RESET_N,
   output logic O_FL_BYTE_WORD_SELECT,
   output logic O_FL_ACCEL_HIGH_VOLTAGE,
   input wire logic I_FL_READY_BUSY_N
);
   typedef enum logic [2:0] {
      FPES_IDLE, FPES_CYCLE, FPES_WAIT, FPES_HWRST, FPES_DRAIN
   } fpes_st_t;

   typedef struct packed {
      fpes_st_t st;
      logic [2:0] idx;
      fpes_op_t op;
      logic [19:0] addr;
      logic [15:0] data;
      logic [31:0] tmr;
      logic busy;
      logic in_secure;
      logic in_bypass;
      logic timer_run;
      logic byte_sel;
      logic accel;
      logic reset_n;
      logic ce_n;
      logic [15:0] rdat;
      logic aw_got;
      logic w_got;
      logic [11:0] awaddr;
      logic [31:0] wdata;
      logic bvalid;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [1:0] bresp;
   } fpes_state_t;
   fpes_state_t s_q, s_d;

   logic [15:0] dq_meta_q, dq_sync_q;
   logic rb_meta_q, rb_sync_q;
   logic cyc_start, cyc_read, cyc_done;
   logic [15:0] cyc_rdata;
   fpes_cyc_t cyc;

   ////////////////////////////////////////////////////////////////////////////////
   // Cycle table of each command sequence; the last entry carries last set.

   function automatic fpes_cyc_t seq_cycle(input fpes_op_t op, input logic [2:0] idx,
                                           input logic [19:0] a, input logic [15:0] d);
      fpes_cyc_t c;
      c = '{addr: `FPES_UNLOCK1_ADDR, data: `FPES_UNLOCK1_DATA, last: 1'b0};
      if (idx == 3'h1 || idx == 3'h4) begin
         c = '{addr: `FPES_UNLOCK2_ADDR, data: `FPES_UNLOCK2_DATA, last: 1'b0};
      end
      case (op)
         FPES_OP_RESET: c = '{addr: a, data: `FPES_CMD_RESET, last: 1'b1};
         FPES_OP_SEC_ENTER: if (idx == 3'h2) c.data = `FPES_CMD_SEC_ENTRY;
         FPES_OP_SEC_EXIT: begin
            if (idx == 3'h2) c.data = `FPES_CMD_EXIT;
            if (idx == 3'h3) c = '{addr: a, data: `FPES_CMD_ZERO, last: 1'b0};
         end
         FPES_OP_PROG: begin
            if (idx == 3'h2) c.data = `FPES_CMD_PROG;
            if (idx == 3'h3) c = '{addr: a, data: d, last: 1'b0};
         end
         FPES_OP_BYP_ENTER: if (idx == 3'h2) c.data = `FPES_CMD_BYPASS;
         FPES_OP_BYP_PROG: c = (idx == 3'h0) ? '{addr: a, data: `FPES_CMD_PROG, last: 1'b0}
                                             : '{addr: a, data: d, last: 1'b0};
         FPES_OP_BYP_EXIT: c = (idx == 3'h0) ? '{addr: a, data: `FPES_CMD_EXIT, last: 1'b0}
                                             : '{addr: a, data: `FPES_CMD_ZERO, last: 1'b0};
         FPES_OP_CHIP_ERASE: begin
            if (idx == 3'h2) c.data = `FPES_CMD_ERASE_SETUP;
            if (idx == 3'h5) c.data = `FPES_CMD_CHIP_ERASE;
         end
         FPES_OP_SECT_ERASE: begin
            if (idx == 3'h2) c.data = `FPES_CMD_ERASE_SETUP;
            if (idx == 3'h5) c = '{addr: a, data: `FPES_CMD_SECT_ERASE, last: 1'b0};
         end
         FPES_OP_SECT_ADD: c = '{addr: a, data: `FPES_CMD_SECT_ERASE, last: 1'b1};
         FPES_OP_SUSPEND: c = '{addr: a, data: `FPES_CMD_SUSPEND, last: 1'b1};
         FPES_OP_READ: c = '{addr: a, data: 16'h0000, last: 1'b1};
         default: c.last = 1'b1;
      endcase
      if (idx == seq_len(op)) c.last = 1'b1;
      return c;
   endfunction

   function automatic logic [2:0] seq_len(input fpes_op_t op);
      case (op)
         FPES_OP_SEC_ENTER, FPES_OP_BYP_ENTER: seq_len = 3'h2;
         FPES_OP_SEC_EXIT, FPES_OP_PROG: seq_len = 3'h3;
         FPES_OP_BYP_PROG, FPES_OP_BYP_EXIT: seq_len = 3'h1;
         FPES_OP_CHIP_ERASE, FPES_OP_SECT_ERASE: seq_len = 3'h5;
         default: seq_len = 3'h0;
      endcase
   endfunction

   // Ops the flash takes in its current mode; others are refused without starting any flash bus cycle.
   function automatic logic op_legal(input fpes_op_t op, input logic byp, input logic tmr,
                                     input logic busy, input logic acc);
      if (op == FPES_OP_RESET) op_legal = !busy && !byp && !acc;
      else if (tmr) op_legal = (op == FPES_OP_SECT_ADD) || (op == FPES_OP_SUSPEND);
      else if (busy) op_legal = (op == FPES_OP_SUSPEND) || (op == FPES_OP_READ);
      else if (byp || acc) op_legal = (op == FPES_OP_BYP_PROG) ||
                                      (op == FPES_OP_BYP_EXIT && !acc) ||
                                      (op == FPES_OP_READ);
      else op_legal = (op != FPES_OP_BYP_PROG) && (op != FPES_OP_BYP_EXIT) &&
                      (op != FPES_OP_SECT_ADD) && (op != FPES_OP_SUSPEND);
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers; the bus is sampled only after two flops.

   always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
      if (I_RST) begin
         dq_meta_q <= 16'h0000;
         dq_sync_q <= 16'h0000;
         rb_meta_q <= 1'b1;
         rb_sync_q <= 1'b1;
      end else begin
         dq_meta_q <= I_FL_DQ;
         dq_sync_q <= dq_meta_q;
         rb_meta_q <= I_FL_READY_BUSY_N;
         rb_sync_q <= rb_meta_q;
      end
   end

   assign cyc = seq_cycle(s_q.op, s_q.idx, s_q.addr, s_q.data);
   assign cyc_read = (s_q.op == FPES_OP_READ);

   fpes_bus_cycle #(
      .LOW_CYC(`FPES_WE_LOW_CYC),
      .HIGH_CYC(`FPES_WE_HIGH_CYC)
   ) u_cycle (
      .i_clk(I_CORE_CLK),
      .i_rst(I_RST),
      .i_start(cyc_start),
      .i_read(cyc_read),
      .i_cyc(cyc),
      .i_dq_sync(dq_sync_q),
      .o_done(cyc_done),
      .o_rdata(cyc_rdata),
      .o_addr(O_FL_ADDR),
      .o_dq(O_FL_DQ),
      .o_dq_oe(O_FL_DQ_OE),
      .o_we_n(O_FL_WE_N),
      .o_oe_n(O_FL_OE_N)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Sequencer and AXI4-Lite slave.

   always_comb begin
      fpes_op_t new_op;
      logic wr_fire;
      new_op = fpes_op_t'(s_q.wdata[`FPES_CTRL_OP_LSB +: `FPES_CTRL_OP_W]);
      s_d = s_q;
      cyc_start = 1'b0;
      wr_fire = 1'b0;
      if (I_AWVALID && !s_q.aw_got && !s_q.bvalid) begin
         s_d.aw_got = 1'b1;
         s_d.awaddr = I_AWADDR;
      end
      if (I_WVALID && !s_q.w_got && !s_q.bvalid) begin
         s_d.w_got = 1'b1;
         s_d.wdata = I_WDATA;
      end
      if (s_q.bvalid && I_BREADY) s_d.bvalid = 1'b0;
      if (s_q.rvalid && I_RREADY) s_d.rvalid = 1'b0;
      if (I_ARVALID && !s_q.rvalid) begin
         s_d.rvalid = 1'b1;
         s_d.rresp = 2'h0;
         case (I_ARADDR)
            `FPES_OFS_CTRL: s_d.rdata = {21'h000000, s_q.reset_n == 1'b0, s_q.byte_sel,
                                         s_q.accel, 4'(s_q.op), 4'h0};
            `FPES_OFS_ADDR: s_d.rdata = {12'h000, s_q.addr};
            `FPES_OFS_DATA: s_d.rdata = {16'h0000, s_q.data};
            `FPES_OFS_STAT: s_d.rdata = {28'h0000000, s_q.in_bypass || s_q.accel, s_q.in_secure,
                                         rb_sync_q, s_q.busy || s_q.st != FPES_IDLE};
            `FPES_OFS_RDAT: s_d.rdata = {16'h0000, s_q.rdat};
            default: begin
               s_d.rdata = 32'h00000000;
               s_d.rresp = 2'h2;
            end
         endcase
      end
      if (s_q.aw_got && s_q.w_got && !s_q.bvalid) begin
         s_d.aw_got = 1'b0;
         s_d.w_got = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp = 2'h0;
         wr_fire = 1'b1;
         case (s_q.awaddr)
            `FPES_OFS_CTRL: begin
               s_d.accel = s_q.wdata[`FPES_CTRL_ACC_BIT];
               s_d.byte_sel = s_q.wdata[`FPES_CTRL_BYTE_BIT];
            end
            `FPES_OFS_ADDR: s_d.addr = s_q.wdata[19:0];
            `FPES_OFS_DATA: s_d.data = s_q.wdata[15:0];
            `FPES_OFS_STAT, `FPES_OFS_RDAT: ;
            default: s_d.bresp = 2'h2;
         endcase
      end
      // Busy drops once the flash reports ready and no erase window is still open, or at the end of a hardware reset.
      if (s_q.busy && rb_sync_q && !s_q.timer_run) s_d.busy = 1'b0;
      case (s_q.st)
         FPES_IDLE: begin
            if (wr_fire && s_q.awaddr == `FPES_OFS_CTRL) begin
               if (s_q.wdata[`FPES_CTRL_RST_BIT]) begin
                  s_d.st = FPES_HWRST;
                  s_d.tmr = 32'h00000000;
                  s_d.reset_n = 1'b0;
               end else if (s_q.wdata[`FPES_CTRL_GO_BIT] &&
                            op_legal(new_op, s_q.in_bypass, s_q.timer_run, s_q.busy,
                                     s_q.accel)) begin
                  s_d.st = FPES_CYCLE;
                  s_d.op = new_op;
                  s_d.idx = 3'h0;
                  s_d.ce_n = 1'b0;
               end
            end else if (s_q.timer_run) begin
               s_d.tmr = s_q.tmr + 32'h00000001;
               if (s_q.tmr >= 32'(TIMEOUT_CYC - 1)) s_d.timer_run = 1'b0;
            end
         end
         FPES_CYCLE: begin
            cyc_start = 1'b1;
            s_d.st = FPES_WAIT;
         end
         FPES_WAIT: begin
            if (cyc_done) begin
               if (cyc.last) begin
                  s_d.st = FPES_IDLE;
                  s_d.ce_n = 1'b1;
                  if (cyc_read) s_d.rdat = cyc_rdata;
                  case (s_q.op)
                     FPES_OP_SEC_ENTER: s_d.in_secure = 1'b1;
                     FPES_OP_SEC_EXIT: s_d.in_secure = 1'b0;
                     FPES_OP_BYP_ENTER: s_d.in_bypass = 1'b1;
                     FPES_OP_BYP_EXIT: s_d.in_bypass = 1'b0;
                     FPES_OP_RESET: s_d.in_bypass = 1'b0;
                     FPES_OP_PROG, FPES_OP_BYP_PROG, FPES_OP_CHIP_ERASE: s_d.busy = 1'b1;
                     FPES_OP_SECT_ERASE, FPES_OP_SECT_ADD: begin
                        s_d.busy = 1'b1;
                        s_d.timer_run = 1'b1;
                        s_d.tmr = 32'h00000000;
                     end
                     FPES_OP_SUSPEND: s_d.timer_run = 1'b0;
                     default: ;
                  endcase
               end else begin
                  s_d.st = FPES_CYCLE;
                  s_d.idx = s_q.idx + 3'h1;
               end
            end
         end
         FPES_HWRST: begin
            s_d.tmr = s_q.tmr + 32'h00000001;
            if (s_q.tmr >= 32'(RST_CYC - 1)) begin
               s_d.st = FPES_DRAIN;
               s_d.reset_n = 1'b1;
               s_d.in_secure = 1'b0;
               s_d.in_bypass = 1'b0;
               s_d.busy = 1'b0;
               s_d.timer_run = 1'b0;
            end
         end
         FPES_DRAIN: s_d.st = FPES_IDLE;
         default: s_d.st = FPES_IDLE;
      endcase
   end

   always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
      if (I_RST) begin
         s_q <= '0;
         s_q.st <= FPES_IDLE;
         s_q.op <= FPES_OP_RESET;
         s_q.reset_n <= 1'b1;
         s_q.ce_n <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign O_AWREADY = !s_q.aw_got && !s_q.bvalid;
   assign O_WREADY = !s_q.w_got && !s_q.bvalid;
   assign O_ARREADY = !s_q.rvalid;
   assign O_BVALID = s_q.bvalid;
   assign O_BRESP = s_q.bresp;
   assign O_RVALID = s_q.rvalid;
   assign O_RDATA = s_q.rdata;
   assign O_RRESP = s_q.rresp;
   assign O_FL_CE_N = s_q.ce_n;
   assign O_FL_RESET_N = s_q.reset_n;
   assign O_FL_BYTE_WORD_SELECT = s_q.byte_sel;
   assign O_FL_ACCEL_HIGH_VOLTAGE = s_q.accel;

   chk_reset_len: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
      $fell(O_FL_RESET_N) |-> !O_FL_RESET_N [*8])
      else $error("flash reset pulse too short");
   chk_busy_refuse: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
      s_q.busy && !s_q.timer_run && s_q.st == FPES_CYCLE |->
      s_q.op == FPES_OP_SUSPEND || s_q.op == FPES_OP_READ)
      else $error("command issued while flash busy");
   chk_window_only: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
      s_q.timer_run && s_q.st == FPES_CYCLE |->
      s_q.op == FPES_OP_SECT_ADD || s_q.op == FPES_OP_SUSPEND)
      else $error("foreign command in erase window");
   chk_bypass_only: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
      s_q.in_bypass && !s_q.busy && s_q.st == FPES_CYCLE |->
      s_q.op inside {FPES_OP_BYP_PROG, FPES_OP_BYP_EXIT, FPES_OP_READ})
      else $error("illegal command in bypass");
   chk_window_bound: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
      s_q.timer_run |-> s_q.tmr < 32'(TIMEOUT_CYC))
      else $error("erase window overran");
   chk_seq_count: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
      s_q.st == FPES_CYCLE |-> s_q.idx <= seq_len(s_q.op))
      else $error("sequence cycle index out of range");
   chk_secure_exit: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
      s_q.st == FPES_HWRST ##1 s_q.st == FPES_DRAIN |-> !s_q.in_secure)
      else $error("secure mode kept over reset");
   chk_ce_frame: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
      !O_FL_WE_N |-> !O_FL_CE_N)
      else $error("write enable outside chip enable");

   cov_prog: cover property (@(posedge I_CORE_CLK) s_q.op == FPES_OP_PROG && cyc_done && cyc.last);
   cov_sect: cover property (@(posedge I_CORE_CLK) $fell(s_q.timer_run));
   cov_byp: cover property (@(posedge I_CORE_CLK) s_q.op == FPES_OP_BYP_PROG && cyc_done);
   cov_rst: cover property (@(posedge I_CORE_CLK) $rose(O_FL_RESET_N));
endmodule

//--- verif/fpes_flash_model.sv
// Behavioural flash bank that logs write cycles and answers array reads.
`timescale 1ns/1ps
module fpes_flash_model (
   input wire logic i_clk,
   input wire logic [19:0] i_addr,
   input wire logic [15:0] i_dq,
   input wire logic i_ce_n,
   input wire logic i_we_n,
   input wire logic i_oe_n,
   input wire logic i_reset_n,
   output logic [15:0] o_dq,
   output logic o_rb_n
);
   logic [35:0] log[$];
   logic [15:0] mem[int];
   logic [15:0] last_q = 16'h0000;
   logic [7:0] prev = 8'h00;
   int busy = 0;
   ////////////////////////////////////////////////////////////////////////////
   // Data is taken on the rising write-enable edge, as the bank latches it.
   always @(posedge i_we_n) begin
      if (!i_ce_n && i_reset_n) begin
         log.push_back({i_addr, i_dq});
         if (busy == 0) begin
            if (prev == 8'hA0) begin
               mem[i_addr] = (mem.exists(i_addr) ? mem[i_addr] : 16'hFFFF) & i_dq;
               busy = 30;
            end
            if (i_dq[7:0] == 8'h10 || i_dq[7:0] == 8'h30) begin
               busy = 60;
            end
            prev = i_dq[7:0];
         end
      end
   end
   always @(posedge i_clk) begin
      if (!i_reset_n) begin
         busy = 0;
         prev = 8'h00;
      end else if (busy > 0) begin
         busy--;
      end
      last_q <= o_dq;
   end
   assign o_rb_n = (busy == 0);
   // An undriven bus keeps changing so a stale value is never read as good.
   assign o_dq = (!i_oe_n && !i_ce_n) ? (mem.exists(i_addr) ? mem[i_addr] : 16'hFFFF) : ~last_q;
endmodule

//--- verif/fpes_ctrl_tb.sv
// Self-checking bench for the flash sequencer controller.
`timescale 1ns/1ps
module fpes_ctrl_tb;
   logic clk = 1'h0;
   logic rst = 1'h1;
   logic awv = 1'h0, wv = 1'h0, bry = 1'h0, arv = 1'h0, rry = 1'h0;
   logic [11:0] awa = 12'h000, ara = 12'h000;
   logic [31:0] wd = 32'h0, rdat;
   logic awr, wr, bv, arr, rv, dq_oe, ce_n, we_n, oe_n, rs_n, bws, acc, rb_n;
   logic [1:0] br, rr, lb;
   logic [19:0] fa;
   logic [15:0] fdo, fdi, mdq;
   int fails = 0, n_checks = 0, cyc = 0;
   always #20 clk = ~clk;
   assign fdi = dq_oe ? fdo : mdq;
   fpes_ctrl #(.TIMEOUT_CYC(20)) dut (.I_CORE_CLK(clk), .I_RST(rst), .I_AWVALID(awv),
      .O_AWREADY(awr), .I_AWADDR(awa), .I_WVALID(wv), .O_WREADY(wr), .I_WDATA(wd),
      .I_WSTRB(4'hF), .O_BVALID(bv), .I_BREADY(bry), .O_BRESP(br), .I_ARVALID(arv),
      .O_ARREADY(arr), .I_ARADDR(ara), .O_RVALID(rv), .I_RREADY(rry), .O_RDATA(rdat),
      .O_RRESP(rr), .O_FL_ADDR(fa), .O_FL_DQ(fdo), .O_FL_DQ_OE(dq_oe), .I_FL_DQ(fdi),
      .O_FL_CE_N(ce_n), .O_FL_WE_N(we_n), .O_FL_OE_N(oe_n), .O_FL_RESET_N(rs_n),
      .O_FL_BYTE_WORD_SELECT(bws), .O_FL_ACCEL_HIGH_VOLTAGE(acc), .I_FL_READY_BUSY_N(rb_n));
   fpes_flash_model fl (.i_clk(clk), .i_addr(fa), .i_dq(fdo), .i_ce_n(ce_n), .i_we_n(we_n),
      .i_oe_n(oe_n), .i_reset_n(rs_n), .o_dq(mdq), .o_rb_n(rb_n));
   ////////////////////////////////////////////////////////////////////////////
   task automatic complete_run;
      $display("checks %0d fails %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         complete_run();
      end
   end
   task automatic check(input logic [35:0] seen, input logic [35:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Signals read right after the edge still hold their pre-edge values.
   task automatic axw(input logic [11:0] a, input logic [31:0] d);
      logic pa = 1'h1, pw = 1'h1, pb = 1'h1;
      awa <= a;
      wd <= d;
      awv <= 1'h1;
      wv <= 1'h1;
      bry <= 1'h1;
      while (pb) begin
         @(posedge clk);
         pb = !(bv && !pa && !pw);
         if (pa && awr) awv <= 1'h0;
         if (pw && wr) wv <= 1'h0;
         pa = pa && !awr;
         pw = pw && !wr;
      end
      // Ready stays high between transfers so it is never lowered and raised in one step.
      lb = br;
   endtask
   task automatic axr(input logic [11:0] a, output logic [31:0] d);
      ara <= a;
      arv <= 1'h1;
      rry <= 1'h1;
      @(posedge clk);
      while (!arr) @(posedge clk);
      arv <= 1'h0;
      @(posedge clk);
      while (!rv) @(posedge clk);
      d = rdat;
   endtask
   task automatic go(input logic [3:0] o, input logic [19:0] a, input logic [15:0] d,
                     input logic [1:0] m = 2'h0);
      fl.log.delete();
      axw(12'h004, {12'h000, a});
      axw(12'h008, {16'h0000, d});
      axw(12'h000, {22'h000000, m, o, 4'h1});
   endtask
   task automatic wt;
      logic [31:0] s = 32'h1;
      while (s[0] === 1'h1) axr(12'h00C, s);
   endtask
   task automatic op(input logic [3:0] o, input logic [19:0] a, input logic [15:0] d,
                     input logic [1:0] m = 2'h0);
      go(o, a, d, m);
      wt();
   endtask
   task automatic cy(input logic [19:0] a, input logic [15:0] d, input bit x = 1'b0);
      logic [35:0] v;
      v = fl.log.pop_front();
      if (x) v[35:16] = a;
      check(v, {a, d});
   endtask
   task automatic unl;
      cy(20'h00555, 16'h00AA);
      cy(20'h002AA, 16'h0055);
   endtask
   task automatic st(input int b, input logic v);
      logic [31:0] s;
      axr(12'h00C, s);
      check(s[b], v);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_prog;
      logic [31:0] r;
      op(4'h3, 20'h12345, 16'h5A0F);
      unl();
      cy(20'h00555, 16'h00A0);
      cy(20'h12345, 16'h5A0F);
      op(4'h3, 20'h12345, 16'hFFF0);
      op(4'hB, 20'h12345, 16'h0000);
      axr(12'h010, r);
      check(r[15:0], 16'h5A00);
   endtask
   task automatic t_sec;
      op(4'h1, 20'h00000, 16'h0000);
      unl();
      cy(20'h00555, 16'h0088);
      st(2, 1'h1);
      op(4'h2, 20'h00000, 16'h0000);
      unl();
      cy(20'h00555, 16'h0090);
      cy(20'h00000, 16'h0000, 1'b1);
      st(2, 1'h0);
      op(4'h1, 20'h00000, 16'h0000);
      axw(12'h000, 32'h00000400);
      check(rs_n, 1'h0);
      wt();
      check(rs_n, 1'h1);
      op(4'h0, 20'h00000, 16'h0000);
      st(2, 1'h0);
      cy(20'h00000, 16'h00F0, 1'b1);
   endtask
   task automatic t_byp;
      op(4'h4, 20'h00000, 16'h0000);
      unl();
      cy(20'h00555, 16'h0020);
      st(3, 1'h1);
      op(4'h5, 20'h00042, 16'h1234);
      cy(20'h00000, 16'h00A0, 1'b1);
      cy(20'h00042, 16'h1234);
      op(4'h6, 20'h00000, 16'h0000);
      cy(20'h00000, 16'h0090, 1'b1);
      cy(20'h00000, 16'h0000, 1'b1);
      st(3, 1'h0);
      axw(12'h000, 32'h00000300);
      check({acc, bws}, 2'h3);
      st(3, 1'h1);
      op(4'h5, 20'h00043, 16'h00FF, 2'h3);
      cy(20'h00000, 16'h00A0, 1'b1);
      cy(20'h00043, 16'h00FF);
      axw(12'h000, 32'h00000000);
      st(3, 1'h0);
   endtask
   task automatic t_erase;
      logic [31:0] r;
      op(4'h7, 20'h00000, 16'h0000);
      unl();
      cy(20'h00555, 16'h0080);
      unl();
      cy(20'h00555, 16'h0010);
      go(4'h8, 20'h3F000, 16'h0000);
      while (fl.log.size() < 6) @(posedge clk);
      unl();
      cy(20'h00555, 16'h0080);
      unl();
      cy(20'h3F000, 16'h0030);
      go(4'h9, 20'h3F800, 16'h0000);
      wt();
      cy(20'h3F800, 16'h0030);
      axr(12'h020, r);
      check({r, rr}, 34'h2);
      axw(12'h020, 32'h00000000);
      check(lb, 2'h2);
   endtask
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'h0;
      @(posedge clk);
      t_prog();
      t_sec();
      t_byp();
      t_erase();
      complete_run();
   end
endmodule
